// File: hdl/adc_ctrl.sv
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module adc_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire adc_ctrl_pkg::apb_req_t apb_req,
  output adc_ctrl_pkg::apb_rsp_t apb_rsp,
  // modulator and filter interface
  input wire logic conv_done,
  input wire logic signed [15:0] raw_code,
  output logic conv_start,
  output logic filter_reset,
  // analog front-end controls
  output adc_ctrl_pkg::front_end_t front_end
);
  import adc_ctrl_pkg::*;

  // register state
  logic [7:0] input_select_code;
  logic [2:0] gain_code;
  logic autozero_enable;
  logic [1:0] conversion_mode_field;
  logic [1:0] burnout_select;
  logic scan_temp_active;
  logic [15:0] gain_error_calibration;
  logic signed [15:0] conversion_result;
  logic data_ready;
  logic signed [15:0] first_code;
  conv_state_t state;

  // bus decode
  wire logic access = apb_req.psel && apb_req.penable;
  // the access phase spans two edges because of the wait state; a
  // register changes only at the completing edge, where pready is high
  wire logic done_edge = access && apb_rsp.pready;
  wire logic wr = done_edge && apb_req.pwrite;
  wire logic hit_cfg = apb_req.paddr == ADDR_CONFIG;
  wire logic hit_ctl = apb_req.paddr == ADDR_CONTROL;
  wire logic hit_cal = apb_req.paddr == ADDR_GAIN_ERROR_CALIBRATION;
  wire logic hit_sts = apb_req.paddr == ADDR_STATUS;
  wire logic hit_res = apb_req.paddr == ADDR_RESULT;
  wire logic mapped = hit_cfg | hit_ctl | hit_cal | hit_sts | hit_res;
  wire logic start_req = wr && hit_ctl && apb_req.pwdata[0];
  wire logic result_read = done_edge && !apb_req.pwrite && hit_res;

  // temperature selection, direct or through scan
  wire logic temp_sel = (input_select_code == TEMP_SELECT_CODE)
    || scan_temp_active;
  wire logic continuous = conversion_mode_field == MODE_CONTINUOUS;

  // auto-zero difference halved, sign kept
  function automatic logic signed [15:0] az_half(
    input logic signed [15:0] a,
    input logic signed [15:0] b
  );
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    // the 17-bit difference cannot overflow; dropping its low bit halves it
    az_half = d[16:1];
  endfunction

  // shift left, then calibration scaling, then rounding and saturation
  function automatic logic signed [15:0] digital_gain(
    input logic signed [15:0] x,
    input logic [1:0] sh,
    input logic [15:0] cal
  );
    logic signed [19:0] s;
    logic signed [36:0] p;
    logic signed [20:0] r;
    s = 20'(x) <<< sh;
    p = 37'(s) * $signed({1'b0, cal});
    r = 21'((p + 37'sh4000) >>> 15); // rounding of the calibrated product
    // a code pushed past full scale saturates rather than wrapping
    if (r > 21'sh07FFF)
      digital_gain = 16'sh7FFF;
    else if (r < -21'sh08000)
      digital_gain = -16'sh8000;
    else
      digital_gain = r[15:0];
  endfunction

  // gain codes above the analog range keep the analog stage at its top
  // and make up the rest by shifting the code
  wire logic [1:0] dig_shift = (gain_code == 3'h6) ? 2'h1 :
    (gain_code == 3'h7) ? 2'h2 : 2'h0;
  wire logic [2:0] ana_gain = (gain_code > AGAIN_MAX) ? AGAIN_MAX
    : gain_code;
  wire logic signed [15:0] az_code = az_half(first_code, raw_code);
  wire logic signed [15:0] pick = autozero_enable ? az_code : raw_code;
  wire logic signed [15:0] scaled =
    digital_gain(pick, dig_shift, gain_error_calibration);

  // next conversion state
  // continuous mode restarts in the cycle after each done, with no gap
  conv_state_t next_state;
  logic next_start;
  always_comb
  begin
    next_state = state;
    next_start = 1'b0;
    unique case (state)
      IDLE:
        if (start_req)
        begin
          next_state = CONV_NORMAL;
          next_start = 1'b1;
        end
      CONV_NORMAL:
        if (conv_done && autozero_enable)
        begin
          next_state = CONV_SWAPPED;
          next_start = 1'b1;
        end
        else if (conv_done && continuous)
          next_start = 1'b1;
        else if (conv_done)
          next_state = IDLE;
      CONV_SWAPPED:
        if (conv_done && continuous)
        begin
          next_state = CONV_NORMAL;
          next_start = 1'b1;
        end
        else if (conv_done)
          next_state = IDLE;
    endcase
  end

  // filter restart goes with every start while auto-zero is on, so each
  // half of a pair sees a clean filter and the pair never mixes
  wire logic next_filter_reset = next_start && autozero_enable;
  // the normal-polarity code is kept for the difference after the swap
  wire logic keep_first = state == CONV_NORMAL && conv_done;

  // sequencer state and start pulses
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= IDLE;
      conv_start <= 1'b0;
      filter_reset <= 1'b0;
    end
    else
    begin
      state <= next_state;
      conv_start <= next_start;
      filter_reset <= next_filter_reset;
    end
  end

  // first code of an auto-zero pair
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      first_code <= 16'sh0000;
    else if (keep_first)
      first_code <= raw_code;
  end

  // a result ends a plain conversion, or the swapped half of a pair
  wire logic result_event = conv_done && (!autozero_enable
    ? state == CONV_NORMAL : state == CONV_SWAPPED);
  // a new result in the cycle of a result read leaves the flag set, so
  // software sees a result that lands at the clearing edge, but one landing at the edge that samples prdata is cleared unseen
  wire logic next_data_ready = result_event || (data_ready && !result_read);

  // result register, loaded only at the end of a result
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      conversion_result <= 16'sh0000;
    else if (result_event)
      conversion_result <= scaled;
  end

  // data ready flag, set wins over read clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      data_ready <= 1'b0;
    else
      data_ready <= next_data_ready;
  end

  // write strobes per register
  wire logic cfg_wr = wr && hit_cfg;
  wire logic cal_wr = wr && hit_cal;

  // next values of the configuration fields; a write replaces them all,
  // otherwise they hold
  wire logic [7:0] next_input_select_code = cfg_wr ? apb_req.pwdata[7:0]
    : input_select_code;
  wire logic [2:0] next_gain_code = cfg_wr ? apb_req.pwdata[GAIN_POS +: 3]
    : gain_code;
  wire logic next_autozero_enable = cfg_wr ? apb_req.pwdata[AZ_POS]
    : autozero_enable;
  wire logic [1:0] next_conversion_mode_field =
    cfg_wr ? apb_req.pwdata[MODE_POS +: 2] : conversion_mode_field;
  // the stored current select survives temperature selection untouched
  wire logic [1:0] next_burnout_select =
    cfg_wr ? apb_req.pwdata[CS_POS +: 2] : burnout_select;
  wire logic next_scan_temp_active = cfg_wr ? apb_req.pwdata[SCAN_TEMP_POS]
    : scan_temp_active;
  wire logic [15:0] next_gain_error_calibration =
    cal_wr ? apb_req.pwdata[15:0] : gain_error_calibration;

  // input selection and scan state
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      input_select_code <= SEL_RESET;
      scan_temp_active <= 1'b0;
      burnout_select <= 2'h0;
    end
    else
    begin
      input_select_code <= next_input_select_code;
      scan_temp_active <= next_scan_temp_active;
      burnout_select <= next_burnout_select;
    end
  end

  // gain and conversion settings
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      gain_code <= GAIN_RESET;
      autozero_enable <= 1'b0;
      conversion_mode_field <= MODE_ONESHOT;
    end
    else
    begin
      gain_code <= next_gain_code;
      autozero_enable <= next_autozero_enable;
      conversion_mode_field <= next_conversion_mode_field;
    end
  end

  // gain calibration, unity after reset
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      gain_error_calibration <= GAIN_ERROR_CALIBRATION_RESET;
    else
      gain_error_calibration <= next_gain_error_calibration;
  end

  // read mux
  wire logic [31:0] cfg_word = {15'h0000, scan_temp_active, burnout_select,
    conversion_mode_field, autozero_enable, gain_code, input_select_code};
  wire logic [31:0] cal_word = {16'h0000, gain_error_calibration};
  wire logic busy = state != IDLE;
  wire logic [31:0] sts_word = {28'h0000000, data_ready, busy, state};
  // the result reads back sign-extended to the bus width
  wire logic [31:0] res_word =
    {{16{conversion_result[15]}}, conversion_result};
  // unmapped places read as zero
  wire logic [31:0] rd_word =
    hit_cfg ? cfg_word :
    hit_cal ? cal_word :
    hit_sts ? sts_word :
    hit_res ? res_word :
    32'h00000000;

  // bus answer registered, one wait state per access
  // pready stands one cycle and prdata is zero outside it
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      apb_rsp <= '0;
    else
    begin
      apb_rsp.pready <= access && !apb_rsp.pready;
      apb_rsp.pslverr <= access && !apb_rsp.pready && !mapped;
      apb_rsp.prdata <= (access && !apb_rsp.pready) ? rd_word : 32'h0;
    end
  end

  // the burnout current is forced off here, never by touching its field,
  // so it comes back as it was once the temperature input is left
  wire logic next_burnout_on = !temp_sel && burnout_select != 2'h0;
  // the swap follows the state that the sequencer enters, so it stands
  // for the whole second half of a pair
  wire logic next_swap = next_state == CONV_SWAPPED;

  // front-end drive
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      front_end <= '0;
    else
    begin
      front_end.temp_route <= temp_sel;
      front_end.burnout_on <= next_burnout_on;
      front_end.temp_bias_on <= temp_sel;
      front_end.burnout_level <= burnout_select;
      front_end.swap_inputs <= next_swap;
      front_end.analog_gain <= ana_gain;
      front_end.digital_shift <= dig_shift;
    end
  end
endmodule

// File: hdl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_GAIN_ERROR_CALIBRATION = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam logic [7:0] TEMP_SELECT_CODE = 8'hDE;
  localparam logic [7:0] SEL_RESET = 8'h01;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h3;
  localparam logic [1:0] MODE_ONESHOT = 2'h2;
  localparam logic [15:0] GAIN_ERROR_CALIBRATION_RESET = 16'h8000;
  localparam logic [2:0] GAIN_RESET = 3'h1;
  localparam int GAIN_POS = 8;
  localparam int AZ_POS = 11;
  localparam int MODE_POS = 12;
  localparam int CS_POS = 14;
  localparam int SCAN_TEMP_POS = 16;
  // analog gain codes drive the front-end selector
  localparam logic [2:0] AGAIN_MAX = 3'h5;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic temp_route;
    logic burnout_on;
    logic temp_bias_on;
    logic swap_inputs;
    logic [1:0] burnout_level;
    logic [2:0] analog_gain;
    logic [1:0] digital_shift;
  } front_end_t;

  typedef enum logic [1:0] {IDLE, CONV_NORMAL, CONV_SWAPPED} conv_state_t;
endpackage

// File: verif/adc_ctrl_monitor.sv
`timescale 1ns/1ps
module adc_ctrl_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire adc_ctrl_pkg::apb_req_t apb_req,
  input wire adc_ctrl_pkg::apb_rsp_t apb_rsp,
  // converter side
  input wire logic conv_done,
  input wire logic signed [15:0] raw_code,
  input wire logic conv_start,
  input wire logic filter_reset,
  input wire adc_ctrl_pkg::front_end_t front_end
);
  import adc_ctrl_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // front-end routing, gain decode and start sequencing
  a_temp_no_burn: assert property (front_end.temp_route |->
    !front_end.burnout_on) else $error("burnout with temp route");
  a_temp_bias_on: assert property (front_end.temp_route |->
    front_end.temp_bias_on) else $error("temp route without bias");
  a_bias_excl: assert property (not (front_end.temp_bias_on &&
    front_end.burnout_on)) else $error("bias and burnout together");
  a_gain_range: assert property (front_end.analog_gain <= AGAIN_MAX)
    else $error("analog gain out of range");
  a_dig_hold: assert property (front_end.digital_shift != 2'h0 |->
    front_end.analog_gain == AGAIN_MAX) else $error("shift below 16x");
  a_shift_max: assert property (front_end.digital_shift != 2'h3)
    else $error("shift too large");
  a_filt_start: assert property (filter_reset |-> conv_start)
    else $error("filter reset alone");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than a pulse");
  c_temp: cover property (front_end.temp_route);
  c_filt: cover property (filter_reset);
  c_shift: cover property (front_end.digital_shift == 2'h2);
endmodule
bind adc_ctrl adc_ctrl_monitor mon (.ref_clk(ref_clk), .rst(rst),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .conv_done(conv_done),
  .raw_code(raw_code), .conv_start(conv_start),
  .filter_reset(filter_reset), .front_end(front_end));

// File: verif/adc_modulator_model.sv
`timescale 1ns/1ps
module adc_modulator_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // start and codes
  input wire logic conv_start,
  input wire logic swap_inputs,
  input wire logic signed [15:0] pos_code,
  input wire logic signed [15:0] neg_code,
  input wire logic [3:0] wait_cycles,
  // result
  output logic conv_done,
  output logic signed [15:0] raw_code
);
  logic [3:0] cnt;
  // counts down after a start; idle code keeps toggling
  always_ff @(posedge ref_clk)
  begin
    conv_done <= 1'b0;
    raw_code <= rst ? 16'h5A5A : ~raw_code;
    if (rst)
      cnt <= 4'h0;
    else if (conv_start)
      cnt <= wait_cycles;
    else if (cnt != 4'h0)
    begin
      cnt <= cnt - 4'h1;
      conv_done <= cnt == 4'h1;
      if (cnt == 4'h1)
        raw_code <= swap_inputs ? neg_code : pos_code;
    end
  end
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  import adc_ctrl_pkg::*;
  logic ref_clk = 0;
  logic rst = 1;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  front_end_t fe;
  logic conv_done, conv_start, filter_reset, err;
  logic signed [15:0] raw_code;
  logic signed [15:0] pos = 0;
  logic signed [15:0] neg = 0;
  logic [3:0] lag = 4'h2;
  logic [31:0] rd;
  int mismatches = 0, samples_checked = 0, n_start = 0, n_filt = 0;
  int cyc = 0, s0, f0;
  adc_ctrl dut (.ref_clk(ref_clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .conv_done(conv_done), .raw_code(raw_code), .conv_start(conv_start),
    .filter_reset(filter_reset), .front_end(fe));
  adc_modulator_model mdl (.ref_clk(ref_clk), .rst(rst),
    .conv_start(conv_start), .swap_inputs(fe.swap_inputs), .pos_code(pos),
    .neg_code(neg), .wait_cycles(lag), .conv_done(conv_done),
    .raw_code(raw_code));
  always #10 ref_clk = ~ref_clk;
  // pulse counters and hang guard
  always @(negedge ref_clk)
  begin
    n_start += conv_start;
    n_filt += filter_reset;
    if (++cyc == 20000)
    begin
      mismatches++;
      finish_test;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      mismatches++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    // hold the request until pready is seen high at a rising edge
    do
      @(posedge ref_clk);
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic conv(input logic [31:0] want, input int starts);
    s0 = n_start;
    f0 = n_filt;
    apb(1'b1, ADDR_CONTROL, 32'h1);
    do
      apb(1'b0, ADDR_STATUS, 32'h0);
    while (rd[3] !== 1'b1);
    apb(1'b0, ADDR_RESULT, 32'h0);
    check(rd, want);
    check(n_start - s0, starts);
    $display("conversion test done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // reset values, unmapped place, gain decode, temp routing, conversions
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check(rd, 32'h0000_2101);
    apb(1'b0, ADDR_GAIN_ERROR_CALIBRATION, 32'h0);
    check(rd, 32'h0000_8000);
    apb(1'b0, 8'h1C, 32'h0);
    check({rd[30:0], err}, 32'h1);
    $display("register test done");
    for (int g = 0; g < 8; g++)
    begin
      apb(1'b1, ADDR_CONFIG, 32'h2001 | (g << GAIN_POS));
      repeat (2) @(negedge ref_clk);
      check(fe.analog_gain, g > 5 ? 5 : g);
      check(fe.digital_shift, g > 5 ? g - 5 : 0);
    end
    $display("gain test done");
    apb(1'b1, ADDR_CONFIG, 32'hE1DE);
    repeat (2) @(negedge ref_clk);
    check({fe.temp_route, fe.burnout_on, fe.temp_bias_on}, 3'h5);
    check(fe.burnout_level, 2'h3);
    apb(1'b1, ADDR_CONFIG, 32'h1E101);
    repeat (2) @(negedge ref_clk);
    check({fe.burnout_on, fe.temp_bias_on}, 2'h1);
    apb(1'b1, ADDR_CONFIG, 32'hE101);
    repeat (2) @(negedge ref_clk);
    check({fe.temp_route, fe.burnout_on, fe.temp_bias_on}, 3'h2);
    $display("front end test done");
    pos <= 100;
    neg <= -60;
    apb(1'b1, ADDR_CONFIG, 32'h2101);
    conv(32'd100, 1);
    lag <= 4'h9;
    apb(1'b1, ADDR_CONFIG, 32'h2901);
    conv(32'd80, 2);
    check(n_filt - f0, 2);
    pos <= 1000;
    apb(1'b1, ADDR_CONFIG, 32'h2701);
    apb(1'b1, ADDR_GAIN_ERROR_CALIBRATION, 32'h4000);
    conv(32'd2000, 1);
    lag <= 4'h2;
    apb(1'b1, ADDR_CONFIG, 32'h3901);
    s0 = n_start;
    f0 = n_filt;
    apb(1'b1, ADDR_CONTROL, 32'h1);
    repeat (40) @(negedge ref_clk);
    apb(1'b1, ADDR_CONFIG, 32'h2901);
    repeat (20) @(negedge ref_clk);
    check(n_start - s0 >= 6, 1);
    check(n_filt - f0, n_start - s0);
    $display("continuous test done");
    finish_test;
  end
endmodule
